// File: design/gag_top.sv
// glyph address generator: command decode, base register, cursor, fetch address
`timescale 1ns/10ps
module gag_top
(
  // clock and reset
  input  wire logic                clk,
  input  wire logic                reset,
  // host parallel port, already decoded into byte strobes
  input  wire gag_pkg::gag_host_t  host,
  // configuration
  input  wire logic                glyph_source_select,
  input  wire logic                glyph_height_select,
  input  wire logic                one_bpp_mode,
  input  wire logic [15:0]         address_pitch,
  // glyph fetch from the display scanner
  input  wire gag_pkg::gag_fetch_t fetch,
  output logic [15:0]              glyph_fetch_address,
  output logic                     use_user_glyph_ram,
  output logic                     user_glyph_allowed,
  // display memory write port
  output logic                     mem_write,
  output logic [15:0]              mem_address,
  output logic [7:0]               mem_data,
  // register views
  output logic [15:0]              glyph_base_address,
  output logic [15:0]              cursor_address,
  output logic [1:0]               cursor_direction,
  output logic                     base_nonzero_error
);

  // ******************************
  // command sequencing
  // ******************************
  gag_pkg::gag_state_t state;
  gag_pkg::gag_state_t next_state;
  logic [7:0]          active_cmd;

  logic is_base_cmd;
  logic is_cursor_cmd;
  logic is_write_cmd;
  logic param_byte;
  logic cursor_low;
  logic cursor_high;
  logic mem_step;

  assign is_base_cmd   = active_cmd == gag_pkg::CMD_GLYPH_BASE_SET;
  assign is_cursor_cmd = active_cmd == gag_pkg::CMD_CURSOR_WRITE;
  assign is_write_cmd  = active_cmd == gag_pkg::CMD_MEMORY_WRITE;
  assign param_byte    = host.write && !host.is_cmd;

  always_comb
  begin
    next_state = state;
    if (host.write && host.is_cmd)
    begin
      if (host.data == gag_pkg::CMD_GLYPH_BASE_SET || host.data == gag_pkg::CMD_CURSOR_WRITE)
        next_state = gag_pkg::GAG_P1;
      else if (host.data == gag_pkg::CMD_MEMORY_WRITE)
        next_state = gag_pkg::GAG_DATA;
      else
        next_state = gag_pkg::GAG_IDLE;
    end
    else if (param_byte)
    begin
      case (state)
        gag_pkg::GAG_P1:   next_state = gag_pkg::GAG_P2;
        gag_pkg::GAG_P2:   next_state = gag_pkg::GAG_IDLE;
        gag_pkg::GAG_DATA: next_state = gag_pkg::GAG_DATA;
        default:           next_state = gag_pkg::GAG_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      state <= gag_pkg::GAG_IDLE;
    else
      state <= next_state;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
      active_cmd <= 8'h00;
    else if (host.write && host.is_cmd)
      active_cmd <= host.data;
  end

  // ******************************
  // glyph base register
  // ******************************
  always_ff @(posedge clk)
  begin
    if (reset)
      glyph_base_address <= gag_pkg::GLYPH_BASE_RESET;
    else if (param_byte && is_base_cmd && state == gag_pkg::GAG_P1)
      glyph_base_address[7:0] <= host.data;
    else if (param_byte && is_base_cmd && state == gag_pkg::GAG_P2)
      glyph_base_address[15:8] <= host.data;
  end

  // rom off requires a zero base; base may be anywhere only with rom in use
  assign base_nonzero_error = glyph_source_select
                            && (glyph_base_address != 16'h0000);

  // ******************************
  // cursor direction
  // ******************************
  always_ff @(posedge clk)
  begin
    if (reset)
      cursor_direction <= gag_pkg::DIR_RESET;
    else if (host.write && host.is_cmd
             && (host.data & gag_pkg::CMD_DIR_MASK) == gag_pkg::CMD_DIR_BASE)
      cursor_direction <= host.data[1:0];
  end

  // ******************************
  // cursor / access address
  // ******************************
  assign cursor_low  = param_byte && is_cursor_cmd && state == gag_pkg::GAG_P1;
  assign cursor_high = param_byte && is_cursor_cmd && state == gag_pkg::GAG_P2;
  assign mem_step    = param_byte && is_write_cmd && state == gag_pkg::GAG_DATA;

  // the same register drives both the shown cursor and the write address
  gag_cursor u_cursor
  (
    .clk            (clk),
    .reset          (reset),
    .load_low       (cursor_low),
    .load_high      (cursor_high),
    .load_data      (host.data),
    .step           (mem_step),
    .direction      (cursor_direction),
    .pitch          (address_pitch),
    .cursor_address (cursor_address)
  );

  // ******************************
  // display memory write
  // ******************************
  // registered so address and data present together with the strobe
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      mem_write   <= 1'b0;
      mem_address <= 16'h0000;
      mem_data    <= 8'h00;
    end
    else
    begin
      mem_write <= mem_step;
      if (mem_step)
      begin
        mem_address <= cursor_address;
        mem_data    <= host.data;
      end
    end
  end

  // ******************************
  // glyph fetch address
  // ******************************
  gag_addr_calc u_calc
  (
    .glyph_base_address  (glyph_base_address),
    .fetch               (fetch),
    .glyph_height_select (glyph_height_select),
    .glyph_source_select (glyph_source_select),
    .glyph_fetch_address (glyph_fetch_address),
    .use_user_glyph_ram  (use_user_glyph_ram)
  );

  // user glyphs only legal at one bit per pixel; rom set sizes live in the package
  assign user_glyph_allowed = one_bpp_mode;

endmodule

// File: design/gag_pkg.sv
// shared constants and types of the glyph address generator
package gag_pkg;

  // ******************************
  // register indices and reset values
  // ******************************
  localparam logic [7:0]  REG_GLYPH_BASE_LOW  = 8'h19;
  localparam logic [7:0]  REG_GLYPH_BASE_HIGH = 8'h1a;
  localparam logic [15:0] GLYPH_BASE_RESET    = 16'h0000;
  localparam logic [15:0] CURSOR_RESET        = 16'h0000;
  localparam logic [1:0]  DIR_RESET           = 2'h0;

  // ******************************
  // config bit positions
  // ******************************
  localparam int SOURCE_SELECT_BIT = 0;
  localparam int HEIGHT_SELECT_BIT = 2;

  // ******************************
  // command codes
  // ******************************
  localparam logic [7:0] CMD_MEMORY_WRITE   = 8'h42;
  localparam logic [7:0] CMD_CURSOR_WRITE   = 8'h46;
  localparam logic [7:0] CMD_GLYPH_BASE_SET = 8'h5c;
  localparam logic [7:0] CMD_DIR_BASE       = 8'h4c;
  localparam logic [7:0] CMD_DIR_MASK       = 8'hfc;

  // ******************************
  // glyph sets
  // ******************************
  localparam int        ROM_GLYPH_COUNT  = 160;
  localparam int        ROM_GLYPH_WIDTH  = 5;
  localparam int        ROM_GLYPH_HEIGHT = 7;
  localparam int        RAM_GLYPH_MIXED_MAX = 64;
  localparam logic [7:0] RAM_LOW_FIRST  = 8'h80;
  localparam logic [7:0] RAM_LOW_LAST   = 8'h9f;
  localparam logic [7:0] RAM_HIGH_FIRST = 8'he0;

  // ******************************
  // cursor step directions
  // ******************************
  localparam logic [1:0] DIR_RIGHT = 2'h0;
  localparam logic [1:0] DIR_LEFT  = 2'h1;
  localparam logic [1:0] DIR_UP    = 2'h2;
  localparam logic [1:0] DIR_DOWN  = 2'h3;

  typedef enum logic [1:0] {
    GAG_IDLE = 2'b00,
    GAG_P1   = 2'b01,
    GAG_P2   = 2'b11,
    GAG_DATA = 2'b10
  } gag_state_t;

  typedef struct packed {
    logic [7:0] code;
    logic [3:0] row;
  } gag_fetch_t;

  typedef struct packed {
    logic        write;
    logic        is_cmd;
    logic [7:0]  data;
  } gag_host_t;

endpackage

// File: design/gag_addr_calc.sv
// glyph fetch address arithmetic and code classification
`timescale 1ns/10ps
module gag_addr_calc
(
  // request
  input  wire logic [15:0]          glyph_base_address,
  input  wire gag_pkg::gag_fetch_t  fetch,
  input  wire logic                 glyph_height_select,
  input  wire logic                 glyph_source_select,
  // result
  output logic [15:0]               glyph_fetch_address,
  output logic                      use_user_glyph_ram
);

  function automatic logic [15:0] position(input logic [7:0] code, input logic [3:0] row,
                                           input logic tall);
    logic [15:0] offs;
    offs = 16'h0000;
    if (tall)
      offs = {4'h0, code, row};
    else
      offs = {5'h00, code, row[2:0]};
    return offs;
  endfunction

  // 16-bit sum drops the carry out of bit 15
  assign glyph_fetch_address = glyph_base_address
                             + position(fetch.code, fetch.row, glyph_height_select);

  // rom in use: two code ranges go to ram; rom off: all codes go to ram
  assign use_user_glyph_ram = glyph_source_select
    || (fetch.code >= gag_pkg::RAM_LOW_FIRST && fetch.code <= gag_pkg::RAM_LOW_LAST)
    || (fetch.code >= gag_pkg::RAM_HIGH_FIRST);

endmodule

// File: design/gag_cursor.sv
// cursor address register with automatic stepping
`timescale 1ns/10ps
module gag_cursor
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // control
  input  wire logic        load_low,
  input  wire logic        load_high,
  input  wire logic [7:0]  load_data,
  input  wire logic        step,
  input  wire logic [1:0]  direction,
  input  wire logic [15:0] pitch,
  // state
  output logic [15:0]      cursor_address
);

  always_ff @(posedge clk)
  begin
    if (reset)
      cursor_address <= gag_pkg::CURSOR_RESET;
    else if (load_low)
      cursor_address <= {cursor_address[15:8], load_data};
    else if (load_high)
      cursor_address <= {load_data, cursor_address[7:0]};
    else if (step)
    begin
      case (direction)
        gag_pkg::DIR_RIGHT: cursor_address <= cursor_address + 16'h0001;
        gag_pkg::DIR_LEFT:  cursor_address <= cursor_address - 16'h0001;
        gag_pkg::DIR_UP:    cursor_address <= cursor_address - pitch;
        gag_pkg::DIR_DOWN:  cursor_address <= cursor_address + pitch;
        default:            cursor_address <= cursor_address;
      endcase
    end
  end

endmodule

// File: testbench/gag_host_model.sv
// host processor model that sends command and parameter bytes
`timescale 1ns/10ps
module gag_host_model
(
  // clock
  input  wire logic        clk,
  // host byte port
  output gag_pkg::gag_host_t host
);
  initial host = '{write: 1'b0, is_cmd: 1'b0, data: 8'h00};

  // one byte per strobe; released data is inverted so stale bytes never look valid
  task automatic put(input logic is_cmd, input logic [7:0] data);
    @(negedge clk);
    host = '{write: 1'b1, is_cmd: is_cmd, data: data};
    @(negedge clk);
    host = '{write: 1'b0, is_cmd: ~is_cmd, data: ~data};
  endtask

  // two-byte load, low byte first
  task automatic cmd2(input logic [7:0] c, input logic [15:0] v);
    put(1'b1, c);
    put(1'b0, v[7:0]);
    put(1'b0, v[15:8]);
  endtask
endmodule

// File: testbench/gag_props.sv
// port assertions for the glyph address generator
`timescale 1ns/10ps
module gag_props
(
  // clock and reset
  input wire logic                clk,
  input wire logic                reset,
  // watched ports
  input wire gag_pkg::gag_host_t  host,
  input wire logic                glyph_source_select,
  input wire logic                glyph_height_select,
  input wire logic                one_bpp_mode,
  input wire gag_pkg::gag_fetch_t fetch,
  input wire logic [15:0]         glyph_fetch_address,
  input wire logic                use_user_glyph_ram,
  input wire logic                user_glyph_allowed,
  input wire logic                mem_write,
  input wire logic [15:0]         mem_address,
  input wire logic [7:0]          mem_data,
  input wire logic [15:0]         glyph_base_address,
  input wire logic [15:0]         cursor_address,
  input wire logic [1:0]          cursor_direction,
  input wire logic                base_nonzero_error
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  a_short_fetch: assert property (
    !glyph_height_select |-> glyph_fetch_address ==
    16'(glyph_base_address + {5'h0, fetch.code, fetch.row[2:0]})) else $error("short fetch");
  a_tall_fetch: assert property (
    glyph_height_select |-> glyph_fetch_address ==
    16'(glyph_base_address + {4'h0, fetch.code, fetch.row})) else $error("tall fetch");
  a_ram_map: assert property (
    use_user_glyph_ram == (glyph_source_select ||
    fetch.code inside {[8'h80:8'h9f], [8'he0:8'hff]})) else $error("ram map");
  a_depth_gate: assert property (
    user_glyph_allowed == one_bpp_mode) else $error("depth gate");
  a_base_flag: assert property (
    base_nonzero_error == (glyph_source_select && glyph_base_address != 16'h0))
    else $error("base flag");
  a_write_addr: assert property (
    mem_write |-> mem_address == $past(cursor_address)) else $error("write address");
  a_write_data: assert property (
    mem_write |-> $past(host.write && !host.is_cmd) && mem_data == $past(host.data))
    else $error("write data");
  a_step_right: assert property (
    mem_write && cursor_direction == 2'h0 |-> cursor_address == 16'(mem_address + 16'h1))
    else $error("step right");
  a_step_left: assert property (
    mem_write && cursor_direction == 2'h1 |-> cursor_address == 16'(mem_address - 16'h1))
    else $error("step left");
  a_base_hold: assert property (
    !$past(host.write) |-> $stable(glyph_base_address)) else $error("base changed");
endmodule

bind gag_top gag_props u_props (.clk, .reset, .host, .glyph_source_select,
  .glyph_height_select, .one_bpp_mode, .fetch, .glyph_fetch_address, .use_user_glyph_ram,
  .user_glyph_allowed, .mem_write, .mem_address, .mem_data, .glyph_base_address,
  .cursor_address, .cursor_direction, .base_nonzero_error);

// File: testbench/tb.sv
// self-checking bench for the glyph address generator
`timescale 1ns/10ps
module tb;
  logic                clk, reset, glyph_source_select, glyph_height_select, one_bpp_mode;
  logic [15:0]         address_pitch, glyph_fetch_address, mem_address;
  logic [15:0]         glyph_base_address, cursor_address, a;
  gag_pkg::gag_fetch_t fetch;
  gag_pkg::gag_host_t  host;
  logic [7:0]          mem_data;
  logic                use_user_glyph_ram, user_glyph_allowed, mem_write, base_nonzero_error;
  logic [1:0]          cursor_direction;
  logic [23:0]         wq[$];
  logic [7:0]          codes[8] = '{8'h00, 8'h7f, 8'h80, 8'h9f, 8'ha0, 8'hdf, 8'he0, 8'hff};
  int                  bad_count, checks_done, cycles;

  gag_host_model hm (.clk, .host);
  gag_top dut (.clk, .reset, .host, .glyph_source_select, .glyph_height_select,
    .one_bpp_mode, .address_pitch, .fetch, .glyph_fetch_address, .use_user_glyph_ram,
    .user_glyph_allowed, .mem_write, .mem_address, .mem_data, .glyph_base_address,
    .cursor_address, .cursor_direction, .base_nonzero_error);

  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // log every memory write; cut a hang short
  always @(posedge clk)
  begin
    cycles++;
    if (mem_write === 1'b1) wq.push_back({mem_address, mem_data});
    if (cycles == 3000)
    begin
      bad_count++;
      summarize();
    end
  end

  task automatic check(input string name, input logic [23:0] exp, input logic [23:0] got);
    checks_done++;
    if (got !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask

  // row bit 3 set on purpose: short glyphs must drop it
  task automatic fchk(input logic [7:0] c, input logic h, input logic [15:0] b);
    logic [15:0] off;
    off = h ? {4'h0, c, 4'hb} : {5'h0, c, 3'h3};
    @(negedge clk);
    fetch = '{code: c, row: 4'hb};
    glyph_height_select = h;
    @(posedge clk);
    #1;
    check("fetch_address", 24'(16'(b + off)), 24'(glyph_fetch_address));
    check("user_ram",
      24'(glyph_source_select | (c inside {[8'h80:8'h9f], [8'he0:8'hff]})),
      24'(use_user_glyph_ram));
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  initial
  begin
    reset = 1'b1;
    {glyph_source_select, glyph_height_select} = 2'b00;
    one_bpp_mode = 1'b1;
    address_pitch = 16'h0028;
    fetch = '{code: 8'h00, row: 4'h0};
    repeat (20) @(negedge clk);
    reset = 1'b0;
    check("base_reset", 24'h0, 24'(glyph_base_address));
    hm.put(1'b0, 8'h55);
    check("refused_byte", 24'h0, 24'(cursor_address));
    hm.cmd2(8'h5c, 16'h4000);
    check("base", 24'h4000, 24'(glyph_base_address));
    hm.cmd2(8'h46, 16'h4800);
    check("cursor", 24'h4800, 24'(cursor_address));
    hm.put(1'b1, 8'h42);
    hm.put(1'b0, 8'h70);
    hm.put(1'b0, 8'h88);
    hm.put(1'b0, 8'hf8);
    a = 16'h4803;
    for (int d = 0; d < 4; d++)
    begin
      hm.put(1'b1, 8'h4c | 8'(d));
      // any command byte ends a write stream, so reopen it
      hm.put(1'b1, 8'h42);
      hm.put(1'b0, 8'(d));
      @(negedge clk);
      check("direction", 24'(d), 24'(cursor_direction));
      check("write", {a, 8'(d)}, wq[3 + d]);
      a = a + (d == 0 ? 16'h1 : d == 1 ? 16'hffff : d == 2 ? -address_pitch : address_pitch);
      check("cursor_step", 24'(a), 24'(cursor_address));
    end
    check("row0", 24'h480070, wq[0]);
    check("row2", 24'h4802f8, wq[2]);
    for (int i = 0; i < 16; i++)
      fchk(codes[i % 8], 1'(i / 8), 16'h4000);
    @(negedge clk);
    glyph_source_select = 1'b1;
    fchk(8'h20, 1'b0, 16'h4000);
    check("base_flag", 24'h1, 24'(base_nonzero_error));
    hm.cmd2(8'h5c, 16'hffff);
    fchk(8'hff, 1'b1, 16'hffff);
    hm.cmd2(8'h5c, 16'h0000);
    check("base_flag", 24'h0, 24'(base_nonzero_error));
    one_bpp_mode = 1'b0;
    @(posedge clk);
    check("depth", 24'h0, 24'(user_glyph_allowed));
    summarize();
  end
endmodule
